/* File: hdl/sld_defs.svh */
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// device register offsets
`define SLD_A_RATE    8'h02
`define SLD_A_CHCTL   8'h04
`define SLD_A_DCTL    8'h09
`define SLD_A_RESA    8'h0C
`define SLD_A_RESB    8'h0D
`define SLD_A_CHREP   8'h0F
// per-channel load threshold registers 0x10..0x13
`define SLD_A_THR_HI  6'h04

// two-bit channel state codes
`define SLD_ST_PLAY   2'h0
`define SLD_ST_HIZ    2'h1
`define SLD_ST_MUTE   2'h2
`define SLD_ST_DIAG   2'h3
`define SLD_ALL_HIZ   8'h55
`define SLD_ALL_DIAG  8'hFF

// diagnostic control fields
`define SLD_DCTL_BYP_M 8'h01
`define SLD_DCTL_BUF   2:1
`define SLD_DCTL_RAMP  4:3
`define SLD_DCTL_SETL  6:5
`define SLD_DCTL_RST   8'h2A
`define SLD_RATE_RST   8'h00
`define SLD_THR_RST    8'h20

// timing
`define SLD_CLK_HZ       40000000
`define SLD_TICK_MS      1
`define SLD_TICK_CYC     (`SLD_CLK_HZ / 1000 * `SLD_TICK_MS)
`define SLD_PREHIZ_MS    5
`define SLD_BUF_UNIT_MS  25
`define SLD_SHORT_MS     50
`define SLD_RAMP_UNIT_MS 10
`define SLD_SETL_UNIT_MS 25
`define SLD_RETRY_MS     1000
`define SLD_SYNC_HZ      2000000
`define SLD_SYNC_HALF    (`SLD_CLK_HZ / (2 * `SLD_SYNC_HZ))

// host controller word registers and fields
`define SLD_H_CMD   2'h0
`define SLD_H_STAT  2'h1
`define SLD_H_CTRL  2'h2
`define SLD_C_STBY  0
`define SLD_C_SYNC  1
`define SLD_C_BYPW  2
`define SLD_C_GO    3
`define SLD_STEP_POLL 3'h3
`define SLD_STEP_RESA 3'h4
`define SLD_STEP_LAST 3'h5

`endif

/* File: hdl/sld_pkg.sv */
`default_nettype none
package sld_pkg;
	typedef enum logic [8:0] {
		SEQ_IDLE   = 9'h001,
		SEQ_PREHIZ = 9'h002,
		SEQ_BUF1   = 9'h004,
		SEQ_SHORT  = 9'h008,
		SEQ_BUF2   = 9'h010,
		SEQ_RUP    = 9'h020,
		SEQ_SETTLE = 9'h040,
		SEQ_RDN    = 9'h080,
		SEQ_DONE   = 9'h100
	} sld_seq_t;
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_ONE  = 4'h2,
		H_WAKE = 4'h4,
		H_DIAG = 4'h8
	} sld_hst_t;
endpackage : sld_pkg
`default_nettype wire

/* File: hdl/sld_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sld_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr;
	logic       rd;
	logic       ack;
	logic       standby;
	logic       sync_clk;
	modport dev  (input addr, input wdata, input wr, input rd, input standby, input sync_clk,
		output rdata, output ack);
	modport host (output addr, output wdata, output wr, output rd, output standby, output sync_clk,
		input rdata, input ack);
endinterface : sld_link_if
`default_nettype wire

/* File: hdl/sld_dev.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sld_defs.svh"
// Summary of operation
// - diagnostics enabled at reset, bypass bit skips
// - leaving high impedance launches diagnostics first
// - host starts diagnostics per channel or all
// - playing channel goes high impedance before testing
// - sequencer timed by internal oscillator only
// - results readable separately per channel
// - four tests: supply, ground, open, shorted
// - supply short also flags battery short
// - own shorted-load threshold per channel
// - impedance above open limit flags open
// - faults retested before report, longer pass
// - buffer delay before both test pairs
// - ramp up, settle-time measurement, then ramp down
// - standby rising with supply runs auto diagnostics
// - faulty auto pass retried about every second
// - channel fault triggers automatic diagnostic run
// - host sets bypass before raising standby
// - all-hiz code places all channels hiz
// - all-ones code enters diagnostics on all
// - report shows all-ones until done, then hiz
// - results stored in two result registers
// - host runs sync clock outside high impedance
module sld_dev #(
	parameter int         TICK_CYC   = `SLD_TICK_CYC,
	parameter logic [7:0] OPEN_LIMIT = 8'hC0
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	sld_link_if.dev          lnk,
	input  wire logic        logic_supply_ok,
	input  wire logic [3:0]  chan_fault,
	input  wire logic [3:0]  meas_supply_short,
	input  wire logic [3:0]  meas_battery_short,
	input  wire logic [3:0]  meas_ground_short,
	input  wire logic [31:0] meas_load,
	output logic      [7:0]  ch_state,
	output logic      [3:0]  ramp_en,
	output logic      [3:0]  test_en
);
	if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_chk
		$error("TICK_CYC out of range");
	end
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

	sld_pkg::sld_seq_t seq_r;
	sld_pkg::sld_seq_t seq_nxt;
	logic [15:0] pre_r;
	logic        tick_r;
	logic [10:0] cnt_r;
	logic [10:0] retry_r;
	logic        retry_on_r;
	logic [7:0]  rate_r;
	logic [7:0]  dctl_r;
	logic [7:0]  chctl_r;
	logic [7:0]  resa_r;
	logic [7:0]  resb_r;
	logic [7:0]  thr_r [4];
	logic [7:0]  st_r;
	logic [7:0]  tgt_r;
	logic [7:0]  wr_tgt;
	logic [7:0]  first_r;
	logic [7:0]  flt_s_r;
	logic [7:0]  flt_l_r;
	logic [7:0]  short_m;
	logic [7:0]  load_m;
	logic [7:0]  rd_mux;
	logic [7:0]  rdata_r;
	logic [3:0]  pend_r;
	logic [3:0]  sel_r;
	logic [3:0]  drv_r;
	logic [3:0]  new_pend;
	logic [3:0]  wr_dir;
	logic [3:0]  open_now;
	logic [3:0]  thin_now;
	logic [3:0]  fault_ch;
	logic [3:0]  ramp_r;
	logic [3:0]  test_r;
	logic        auto_pend_r;
	logic        auto_run_r;
	logic        rt_r;
	logic        stby_q_r;
	logic        ack_r;
	logic        wr_go;
	logic        byp;
	logic        take;
	logic        ph_end;
	logic        reload;
	logic        auto_req;
	logic        retry_fire;

	function automatic logic [10:0] ph_len(input sld_pkg::sld_seq_t s, input logic [7:0] c);
		// one tick is one millisecond
		case (s)
			sld_pkg::SEQ_PREHIZ: ph_len = 11'(`SLD_PREHIZ_MS - 1);
			sld_pkg::SEQ_BUF1,
			sld_pkg::SEQ_BUF2:   ph_len = 11'((int'(c[`SLD_DCTL_BUF]) + 1) * `SLD_BUF_UNIT_MS - 1);
			sld_pkg::SEQ_SHORT:  ph_len = 11'(`SLD_SHORT_MS - 1);
			sld_pkg::SEQ_RUP,
			sld_pkg::SEQ_RDN:    ph_len = 11'((int'(c[`SLD_DCTL_RAMP]) + 1) * `SLD_RAMP_UNIT_MS - 1);
			sld_pkg::SEQ_SETTLE: ph_len = 11'((int'(c[`SLD_DCTL_SETL]) + 1) * `SLD_SETL_UNIT_MS - 1);
			default:             ph_len = 11'h000;
		endcase
	endfunction : ph_len

	assign wr_go      = lnk.wr && !ack_r;
	assign byp        = |(dctl_r & `SLD_DCTL_BYP_M);
	assign take       = (seq_r == sld_pkg::SEQ_IDLE) && (|pend_r);
	assign ph_end     = tick_r && (cnt_r == 11'h000);
	assign retry_fire = retry_on_r && tick_r && (retry_r == 11'h000);
	assign short_m    = {meas_ground_short, meas_supply_short | meas_battery_short} & {sel_r, sel_r};
	assign load_m     = {thin_now, open_now} & {sel_r, sel_r};
	assign fault_ch   = sel_r & (flt_s_r[3:0] | flt_s_r[7:4] | flt_l_r[3:0] | flt_l_r[7:4]);
	assign lnk.ack    = ack_r;
	assign lnk.rdata  = rdata_r;
	assign ch_state   = st_r;
	assign ramp_en    = ramp_r;
	assign test_en    = test_r;

	// the internal oscillator alone paces the tests; the sync pin is never used here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (pre_r == TICK_LAST);
			pre_r  <= (pre_r == TICK_LAST) ? 16'h0000 : pre_r + 16'h0001;
		end
	end

	always_comb begin
		if (lnk.addr == `SLD_A_RATE) rd_mux = rate_r;
		else if (lnk.addr == `SLD_A_CHCTL) rd_mux = chctl_r;
		else if (lnk.addr == `SLD_A_DCTL) rd_mux = dctl_r;
		else if (lnk.addr == `SLD_A_RESA) rd_mux = resa_r;
		else if (lnk.addr == `SLD_A_RESB) rd_mux = resb_r;
		else if (lnk.addr == `SLD_A_CHREP) rd_mux = st_r;
		else if (lnk.addr[7:2] == `SLD_A_THR_HI) rd_mux = thr_r[lnk.addr[1:0]];
		else rd_mux = 8'h00;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= (lnk.wr || lnk.rd) && !ack_r;
			if (lnk.rd && !ack_r)
				rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rate_r  <= `SLD_RATE_RST;
			chctl_r <= `SLD_ALL_HIZ;
			dctl_r  <= `SLD_DCTL_RST;
			for (int i = 0; i < 4; i++)
				thr_r[i] <= `SLD_THR_RST;
		end else if (wr_go) begin
			if (lnk.addr == `SLD_A_RATE) rate_r <= lnk.wdata;
			else if (lnk.addr == `SLD_A_CHCTL) chctl_r <= lnk.wdata;
			else if (lnk.addr == `SLD_A_DCTL) dctl_r <= lnk.wdata;
			else if (lnk.addr[7:2] == `SLD_A_THR_HI) thr_r[lnk.addr[1:0]] <= lnk.wdata;
		end
	end

	always_comb begin
		auto_req = ((lnk.standby && !stby_q_r && logic_supply_ok)
			|| (|chan_fault)
			|| retry_fire) && !byp;
		new_pend = 4'h0;
		wr_dir   = 4'h0;
		wr_tgt   = tgt_r;
		for (int i = 0; i < 4; i++) begin
			open_now[i] = meas_load[8*i +: 8] > OPEN_LIMIT;
			thin_now[i] = meas_load[8*i +: 8] < thr_r[i];
			if (st_r[2*i +: 2] != `SLD_ST_DIAG) begin
				if (auto_req) begin
					new_pend[i]      = 1'b1;
					wr_tgt[2*i +: 2] = `SLD_ST_HIZ;
				end else if (wr_go && lnk.addr == `SLD_A_CHCTL) begin
					if (lnk.wdata[2*i +: 2] == `SLD_ST_DIAG) begin
						new_pend[i]      = 1'b1;
						wr_tgt[2*i +: 2] = `SLD_ST_HIZ;
					end else if (lnk.wdata[2*i +: 2] != `SLD_ST_HIZ
						&& st_r[2*i +: 2] == `SLD_ST_HIZ && !byp) begin
						new_pend[i]      = 1'b1;
						wr_tgt[2*i +: 2] = lnk.wdata[2*i +: 2];
					end else begin
						wr_dir[i] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r        <= `SLD_ALL_HIZ;
			tgt_r       <= `SLD_ALL_HIZ;
			drv_r       <= 4'h0;
			pend_r      <= 4'h0;
			auto_pend_r <= 1'b0;
			stby_q_r    <= 1'b0;
		end else begin
			stby_q_r    <= lnk.standby;
			tgt_r       <= wr_tgt;
			pend_r      <= (take ? 4'h0 : pend_r) | new_pend;
			auto_pend_r <= (take ? 1'b0 : auto_pend_r) | (auto_req && (|new_pend));
			for (int i = 0; i < 4; i++) begin
				if (new_pend[i]) begin
					st_r[2*i +: 2] <= `SLD_ST_DIAG;
					drv_r[i]       <= !st_r[2*i];
				end else if (wr_dir[i]) begin
					st_r[2*i +: 2] <= lnk.wdata[2*i +: 2];
				end else if (seq_r == sld_pkg::SEQ_DONE && sel_r[i]) begin
					// a failing channel never proceeds to mute or play
					st_r[2*i +: 2] <= fault_ch[i] ? `SLD_ST_HIZ : tgt_r[2*i +: 2];
				end
			end
		end
	end

	always_comb begin
		seq_nxt = seq_r;
		reload  = 1'b0;
		case (seq_r)
			sld_pkg::SEQ_IDLE: begin
				if (|pend_r)
					seq_nxt = (|(pend_r & drv_r)) ? sld_pkg::SEQ_PREHIZ : sld_pkg::SEQ_BUF1;
			end
			sld_pkg::SEQ_PREHIZ: if (ph_end) seq_nxt = sld_pkg::SEQ_BUF1;
			sld_pkg::SEQ_BUF1:   if (ph_end) seq_nxt = sld_pkg::SEQ_SHORT;
			sld_pkg::SEQ_SHORT: begin
				if (ph_end && !rt_r && (|short_m)) reload = 1'b1;
				else if (ph_end) seq_nxt = sld_pkg::SEQ_BUF2;
			end
			sld_pkg::SEQ_BUF2:   if (ph_end) seq_nxt = sld_pkg::SEQ_RUP;
			sld_pkg::SEQ_RUP:    if (ph_end) seq_nxt = sld_pkg::SEQ_SETTLE;
			sld_pkg::SEQ_SETTLE: begin
				if (ph_end && !rt_r && (|load_m)) reload = 1'b1;
				else if (ph_end) seq_nxt = sld_pkg::SEQ_RDN;
			end
			sld_pkg::SEQ_RDN:    if (ph_end) seq_nxt = sld_pkg::SEQ_DONE;
			default:             seq_nxt = sld_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_r <= sld_pkg::SEQ_IDLE;
			cnt_r <= 11'h000;
		end else begin
			seq_r <= seq_nxt;
			if (seq_nxt != seq_r || reload)
				cnt_r <= ph_len(seq_nxt, dctl_r);
			else if (tick_r && cnt_r != 11'h000)
				cnt_r <= cnt_r - 11'h001;
		end
	end

	// a fault is reported only if both the first sample and the retest see it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sel_r      <= 4'h0;
			auto_run_r <= 1'b0;
			rt_r       <= 1'b0;
			first_r    <= 8'h00;
			flt_s_r    <= 8'h00;
			flt_l_r    <= 8'h00;
		end else if (take) begin
			sel_r      <= pend_r;
			auto_run_r <= auto_pend_r;
			rt_r       <= 1'b0;
			flt_s_r    <= 8'h00;
			flt_l_r    <= 8'h00;
		end else if (ph_end && (seq_r == sld_pkg::SEQ_SHORT || seq_r == sld_pkg::SEQ_SETTLE)) begin
			if (!rt_r && (|((seq_r == sld_pkg::SEQ_SHORT) ? short_m : load_m))) begin
				rt_r    <= 1'b1;
				first_r <= (seq_r == sld_pkg::SEQ_SHORT) ? short_m : load_m;
			end else if (seq_r == sld_pkg::SEQ_SHORT) begin
				rt_r    <= 1'b0;
				flt_s_r <= rt_r ? (first_r & short_m) : short_m;
			end else begin
				rt_r    <= 1'b0;
				flt_l_r <= rt_r ? (first_r & load_m) : load_m;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			resa_r <= 8'h00;
			resb_r <= 8'h00;
		end else if (seq_r == sld_pkg::SEQ_DONE) begin
			resa_r <= (resa_r & ~{sel_r, sel_r}) | flt_s_r;
			resb_r <= (resb_r & ~{sel_r, sel_r}) | flt_l_r;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			retry_on_r <= 1'b0;
			retry_r    <= 11'h000;
		end else if (!lnk.standby || byp) begin
			retry_on_r <= 1'b0;
		end else if (seq_r == sld_pkg::SEQ_DONE && auto_run_r && (|fault_ch)) begin
			retry_on_r <= 1'b1;
			retry_r    <= 11'(`SLD_RETRY_MS - 1);
		end else if (retry_on_r && tick_r) begin
			if (retry_r == 11'h000)
				retry_on_r <= 1'b0;
			else
				retry_r <= retry_r - 11'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ramp_r <= 4'h0;
			test_r <= 4'h0;
		end else begin
			ramp_r <= (seq_r == sld_pkg::SEQ_RUP || seq_r == sld_pkg::SEQ_RDN) ? sel_r : 4'h0;
			test_r <= (seq_r == sld_pkg::SEQ_SHORT || seq_r == sld_pkg::SEQ_SETTLE) ? sel_r : 4'h0;
		end
	end
endmodule : sld_dev
`default_nettype wire

/* File: hdl/sld_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sld_defs.svh"
module sld_host (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	sld_link_if.host         lnk,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	sld_pkg::sld_hst_t hst_r;
	logic [2:0]  step_r;
	logic [7:0]  addr_r;
	logic [7:0]  wdata_r;
	logic [7:0]  rdata_r;
	logic [7:0]  res_a_r;
	logic [7:0]  res_b_r;
	logic [7:0]  par_r;
	logic [7:0]  chsh_r;
	logic [7:0]  div_r;
	logic [31:0] rdd_r;
	logic [31:0] rd_mux;
	logic [16:0] op;
	logic        wr_r;
	logic        rd_r;
	logic        op_on_r;
	logic        stby_r;
	logic        sync_en_r;
	logic        byp_wake_r;
	logic        sync_clk_r;
	logic        wait_r;
	logic        act_wr;
	logic        cmd_wr;
	logic        ctl_wr;
	logic        wake;
	logic        issue;
	logic        sync_run;

	function automatic logic [16:0] step_op(input logic [2:0] s, input logic [7:0] par);
		case (s)
			3'h0:                 step_op = {1'b0, `SLD_A_CHCTL, `SLD_ALL_HIZ};
			3'h1:                 step_op = {1'b0, `SLD_A_DCTL, par};
			3'h2:                 step_op = {1'b0, `SLD_A_CHCTL, `SLD_ALL_DIAG};
			`SLD_STEP_POLL:       step_op = {1'b1, `SLD_A_CHREP, 8'h00};
			`SLD_STEP_RESA:       step_op = {1'b1, `SLD_A_RESA, 8'h00};
			default:              step_op = {1'b1, `SLD_A_RESB, 8'h00};
		endcase
	endfunction : step_op

	assign act_wr   = avs_write && !wait_r;
	assign cmd_wr   = act_wr && avs_address == `SLD_H_CMD;
	assign ctl_wr   = act_wr && avs_address == `SLD_H_CTRL;
	assign wake     = ctl_wr && avs_writedata[`SLD_C_STBY] && !stby_r;
	// sync must run whenever any channel may be out of high impedance
	assign sync_run = sync_en_r || ((chsh_r & `SLD_ALL_HIZ) != `SLD_ALL_HIZ);
	assign avs_readdata    = rdd_r;
	assign avs_waitrequest = wait_r;
	assign lnk.addr     = addr_r;
	assign lnk.wdata    = wdata_r;
	assign lnk.wr       = wr_r;
	assign lnk.rd       = rd_r;
	assign lnk.standby  = stby_r;
	assign lnk.sync_clk = sync_clk_r;

	always_comb begin
		if (avs_address == `SLD_H_CMD) rd_mux = {15'h0000, rd_r, addr_r, wdata_r};
		else if (avs_address == `SLD_H_STAT) rd_mux = {res_b_r, res_a_r, 7'h00, hst_r != sld_pkg::H_IDLE, rdata_r};
		else if (avs_address == `SLD_H_CTRL) rd_mux = {16'h0000, par_r, 5'h00, byp_wake_r, sync_en_r, stby_r};
		else rd_mux = 32'h00000000;
	end

	// every access answers on the second cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
			rdd_r  <= 32'h00000000;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
			if (avs_read && wait_r)
				rdd_r <= rd_mux;
		end
	end

	always_comb begin
		issue = 1'b0;
		op    = step_op(step_r, par_r);
		if (hst_r == sld_pkg::H_IDLE && cmd_wr) begin
			issue = 1'b1;
			op    = avs_writedata[16:0];
		end else if (hst_r == sld_pkg::H_IDLE && wake && avs_writedata[`SLD_C_BYPW]) begin
			issue = 1'b1;
			op    = {1'b0, `SLD_A_DCTL, avs_writedata[15:8] | `SLD_DCTL_BYP_M};
		end else if (hst_r == sld_pkg::H_DIAG && !op_on_r) begin
			issue = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			op_on_r <= 1'b0;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
			addr_r  <= 8'h00;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
			chsh_r  <= `SLD_ALL_HIZ;
		end else if (issue) begin
			op_on_r <= 1'b1;
			rd_r    <= op[16];
			wr_r    <= !op[16];
			addr_r  <= op[15:8];
			wdata_r <= op[7:0];
			if (!op[16] && op[15:8] == `SLD_A_CHCTL)
				chsh_r <= op[7:0];
		end else if (op_on_r && lnk.ack) begin
			op_on_r <= 1'b0;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
			if (rd_r)
				rdata_r <= lnk.rdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hst_r      <= sld_pkg::H_IDLE;
			step_r     <= 3'h0;
			stby_r     <= 1'b0;
			sync_en_r  <= 1'b0;
			byp_wake_r <= 1'b0;
			par_r      <= `SLD_DCTL_RST;
			res_a_r    <= 8'h00;
			res_b_r    <= 8'h00;
		end else begin
			if (ctl_wr) begin
				sync_en_r  <= avs_writedata[`SLD_C_SYNC];
				byp_wake_r <= avs_writedata[`SLD_C_BYPW];
				par_r      <= avs_writedata[15:8];
				if (!avs_writedata[`SLD_C_STBY])
					stby_r <= 1'b0;
			end
			case (hst_r)
				sld_pkg::H_IDLE: begin
					if (cmd_wr)
						hst_r <= sld_pkg::H_ONE;
					else if (wake && avs_writedata[`SLD_C_BYPW])
						hst_r <= sld_pkg::H_WAKE;
					else if (wake)
						stby_r <= 1'b1;
					else if (ctl_wr && avs_writedata[`SLD_C_GO]) begin
						step_r <= 3'h0;
						hst_r  <= sld_pkg::H_DIAG;
					end
				end
				sld_pkg::H_ONE: if (op_on_r && lnk.ack) hst_r <= sld_pkg::H_IDLE;
				sld_pkg::H_WAKE: begin
					// standby rises only once the bypass write is taken
					if (op_on_r && lnk.ack) begin
						stby_r <= 1'b1;
						hst_r  <= sld_pkg::H_IDLE;
					end
				end
				sld_pkg::H_DIAG: begin
					if (op_on_r && lnk.ack) begin
						if (step_r == `SLD_STEP_POLL && lnk.rdata != `SLD_ALL_HIZ) begin
							step_r <= step_r;
						end else if (step_r == `SLD_STEP_LAST) begin
							res_b_r <= lnk.rdata;
							hst_r   <= sld_pkg::H_IDLE;
						end else begin
							if (step_r == `SLD_STEP_RESA)
								res_a_r <= lnk.rdata;
							step_r <= step_r + 3'h1;
						end
					end
				end
				default: hst_r <= sld_pkg::H_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_r      <= 8'h00;
			sync_clk_r <= 1'b0;
		end else if (!sync_run) begin
			div_r      <= 8'h00;
			sync_clk_r <= 1'b0;
		end else if (div_r == 8'(`SLD_SYNC_HALF - 1)) begin
			div_r      <= 8'h00;
			sync_clk_r <= !sync_clk_r;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end
endmodule : sld_host
`default_nettype wire

/* File: sim/sld_link_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sld_link_checker (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic       ack,
	input wire logic       standby,
	input wire logic       sync_clk
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_excl; !(wr && rd); endproperty
	a_excl: assert property (p_excl) else $error("link read and write together");
	property p_ack; $rose(wr || rd) |=> ack; endproperty
	a_ack: assert property (p_ack) else $error("link answer late");
	property p_pulse; ack |=> !ack && !wr && !rd; endproperty
	a_pulse: assert property (p_pulse) else $error("ack or request too long");
	property p_hold; (wr || rd) && !ack |=> (wr || rd) && $stable(addr) && $stable(wdata); endproperty
	a_hold: assert property (p_hold) else $error("request changed before ack");
	property p_cause; ack |-> (wr || rd); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	property p_rdat; $changed(rdata) |-> ack && rd; endproperty
	a_rdat: assert property (p_rdat) else $error("read data moved outside a read");
	property p_sync_hi; $rose(sync_clk) |-> sync_clk [*8] ##3 !sync_clk; endproperty
	a_sync_hi: assert property (p_sync_hi) else $error("sync high phase wrong");
	property p_sync_lo; $fell(sync_clk) |-> !sync_clk [*8]; endproperty
	a_sync_lo: assert property (p_sync_lo) else $error("sync low phase short");
	c_go: cover property (ack && wr && addr == 8'h04 && wdata == 8'hFF);
	c_poll: cover property (ack && rd && addr == 8'h0F && rdata == 8'h55);
	c_wake: cover property ($rose(standby));
endmodule : sld_link_checker
`default_nettype wire

/* File: sim/tb_speaker_load_diagnostic_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_speaker_load_diagnostic_sequencer;
	localparam int TC = 4;
	logic        sys_clk;
	logic        rst;
	logic        sup_ok;
	logic [3:0]  cfault;
	logic [3:0]  s_sup;
	logic [3:0]  s_bat;
	logic [3:0]  s_gnd;
	logic [31:0] load;
	logic [7:0]  ch_state;
	logic [1:0]  av_a;
	logic        av_rd;
	logic        av_wr;
	logic [31:0] av_wd;
	logic [31:0] av_q;
	logic        av_wait;
	logic [31:0] rdq;
	logic [7:0]  thr [4];
	logic [7:0]  ld [4];
	logic [3:0]  ten;
	logic [3:0]  ren;
	int          ton;
	int          ron;
	int          miscompares;
	int          checks;
	int unsigned seed;
	sld_link_if lnk ();
	sld_dev #(.TICK_CYC(TC)) i_sld_dev (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .logic_supply_ok(sup_ok),
		.chan_fault(cfault), .meas_supply_short(s_sup), .meas_battery_short(s_bat), .meas_ground_short(s_gnd),
		.meas_load(load), .ch_state(ch_state), .ramp_en(ren), .test_en(ten));
	sld_host i_sld_host (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .avs_address(av_a), .avs_read(av_rd),
		.avs_write(av_wr), .avs_writedata(av_wd), .avs_readdata(av_q), .avs_waitrequest(av_wait));
	sld_link_checker i_sld_link_checker (.sys_clk(sys_clk), .rst(rst), .addr(lnk.addr), .wdata(lnk.wdata),
		.rdata(lnk.rdata), .wr(lnk.wr), .rd(lnk.rd), .ack(lnk.ack), .standby(lnk.standby), .sync_clk(lnk.sync_clk));
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		av_a <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wd <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (av_wait !== 1'b0 && n < 50);
		if (n >= 50) begin
			cmp(32'h0, 32'h1);
			give_verdict();
		end
		rdq = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic dev_acc(input logic r, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		bus(2'h0, 1'b1, {15'h0, r, a, d});
		do begin
			bus(2'h1, 1'b0, 32'h0);
			n++;
		end while (rdq[8] !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			cmp(32'h0, 32'h1);
			give_verdict();
		end
	endtask : dev_acc
	task automatic span(input logic [7:0] v, input int lim, output int n);
		n = 0;
		while (ch_state === v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : span
	// cycles with any channel measured or ramping, for the phase lengths
	always @(posedge sys_clk) begin
		if (ten != 4'h0) ton <= ton + 1;
		if (ren != 4'h0) ron <= ron + 1;
	end
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		int n;
		logic [47:0] ra;
		logic [47:0] rx;
		logic [7:0]  eb;
		{rst, sup_ok, seed, miscompares, checks} = {1'b1, 1'b1, 32'd20, 64'd0};
		{cfault, s_sup, s_bat, s_gnd, load, av_a, av_rd, av_wr, av_wd} = '0;
		{ton, ron} = 64'd0;
		ra = 48'h02_04_09_0C_0D_0F;
		rx = 48'h00_55_2A_00_00_55;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			dev_acc(1'b1, ra[47-8*i -: 8], 8'h00);
			cmp(rdq[7:0], rx[47-8*i -: 8]);
		end
		bus(2'h3, 1'b0, 32'h0);
		cmp(rdq, 32'h0);
		eb = 8'h00;
		for (int k = 0; k < 4; k++) begin
			dev_acc(1'b1, 8'h10 + 8'(k), 8'h00);
			cmp(rdq[7:0], 8'h20);
			thr[k] = 8'h30 + (xs() & 8'h3F);
			ld[k] = (k == 0) ? 8'hC0 : (k == 1) ? 8'hC1 : xs();
			dev_acc(1'b0, 8'h10 + 8'(k), thr[k]);
			eb[k] = ld[k] > 8'hC0;
			eb[k+4] = ld[k] < thr[k];
		end
		load <= {ld[3], ld[2], ld[1], ld[0]};
		{s_sup, s_bat, s_gnd} <= 12'h284;
		bus(2'h2, 1'b1, 32'h0000_000A);
		span(8'h55, 400, n);
		cmp(ch_state, 8'hFF);
		span(8'hFF, 400 * TC, n);
		cmp({31'h0, n >= 216 * TC && n <= 224 * TC}, 32'h1);
		cmp(ton, 150 * TC);
		cmp(ron, 20 * TC);
		dev_acc(1'b1, 8'h0F, 8'h00);
		cmp(rdq[31:16], {eb, 8'h4A});
		cmp(ch_state, 8'h55);
		bus(2'h2, 1'b1, 32'h0000_0003);
		span(8'h55, 400, n);
		cmp(ch_state, 8'hFF);
		span(8'hFF, 400 * TC, n);
		{s_sup, s_bat, s_gnd} <= 12'h000;
		load <= 32'h80808080;
		span(8'h55, 1100 * TC, n);
		cmp({31'h0, n >= 995 * TC && n <= 1005 * TC}, 32'h1);
		span(8'hFF, 400 * TC, n);
		span(8'h55, 1100 * TC, n);
		cmp(n, 1100 * TC);
		cfault <= 4'h4;
		span(8'h55, 400, n);
		cmp(ch_state, 8'hFF);
		cfault <= 4'h0;
		span(8'hFF, 400 * TC, n);
		dev_acc(1'b0, 8'h09, 8'h01);
		cfault <= 4'h2;
		span(8'h55, 300, n);
		cmp(n, 300);
		cfault <= 4'h0;
		dev_acc(1'b0, 8'h09, 8'h00);
		dev_acc(1'b0, 8'h04, 8'h00);
		cmp(ch_state, 8'hFF);
		span(8'hFF, 400 * TC, n);
		cmp(ch_state, 8'h00);
		// one channel back to test while the others keep playing
		dev_acc(1'b0, 8'h04, 8'h03);
		cmp(ch_state, 8'h03);
		span(8'h03, 400 * TC, n);
		cmp({31'h0, n >= 145 * TC && n <= 152 * TC}, 32'h1);
		cmp(ch_state, 8'h01);
		bus(2'h2, 1'b1, 32'h0000_0002);
		sup_ok <= 1'b0;
		bus(2'h2, 1'b1, 32'h0000_0003);
		span(8'h01, 300, n);
		cmp(n, 300);
		bus(2'h2, 1'b1, 32'h0000_0002);
		sup_ok <= 1'b1;
		bus(2'h2, 1'b1, 32'h0000_0007);
		span(8'h01, 300, n);
		cmp(n, 300);
		dev_acc(1'b1, 8'h09, 8'h00);
		cmp(rdq[7:0], 8'h01);
		give_verdict();
	end
endmodule : tb_speaker_load_diagnostic_sequencer
`default_nettype wire
